// ---- ifm_pkg.sv ----
// Purpose: Shared constants and types for the two-wire memory slave.
// Assumes: System clock of 10 MHz, bus clock of at most 1 MHz.
// Notes:   Widths, depths and header fields live here; slices such as 6:0, steps such as 4'h1 and byte widths in the bench are written inline.
package ifm_pkg;
  localparam int CLK_HZ       = 10_000_000;
  localparam int SCL_MAX_HZ   = 1_000_000;
  // Least system cycles in one bus clock phase at the fastest bus rate.
  localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_MAX_HZ);
  localparam int ADDR_W       = 15;
  localparam int DATA_W       = 8;
  localparam int MEM_DEPTH    = 32768;
  localparam int FIFO_DEPTH   = 8;
  localparam int SEL_W        = 3;
  localparam int ENTRY_W      = ADDR_W + DATA_W;
  localparam int SA_TYPE_HI   = 7;
  localparam int SA_TYPE_LO   = 4;
  localparam int SA_SEL_HI    = 3;
  localparam int SA_SEL_LO    = 1;
  localparam int SA_RW        = 0;
  localparam logic [3:0]  BYTE_BITS = 4'h8;
  localparam logic [3:0]  DEV_TYPE  = 4'ha;
  localparam logic [14:0] ADDR_TOP  = 15'h7fff;
  localparam logic [14:0] ADDR_ZERO = 15'h0000;
  localparam logic [14:0] ADDR_ONE  = 15'h0001;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_ACK,
    ST_SEND,
    ST_RACK
  } ifm_state_t;

  typedef enum logic [1:0] {
    PH_DEV,
    PH_AHI,
    PH_ALO,
    PH_DATA
  } ifm_phase_t;
endpackage

// ---- ifm_fifo.sv ----
// Purpose: Small first-in first-out buffer with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty come from pointers one bit wider than the index.
`timescale 1ns/1ns
module ifm_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } ifm_fifo_st_t;

  ifm_fifo_st_t f_reg;
  ifm_fifo_st_t f_next;

  assign rd_valid = (f_reg.wp != f_reg.rp);
  assign wr_ready = (f_reg.wp[AW-1:0] != f_reg.rp[AW-1:0]) || (f_reg.wp[AW] == f_reg.rp[AW]);
  assign rd_data  = f_reg.mem[f_reg.rp[AW-1:0]];

  always_comb begin
    f_next = f_reg;
    if (wr_valid && wr_ready) begin
      f_next.mem[f_reg.wp[AW-1:0]] = wr_data;
      f_next.wp = f_reg.wp + 1'b1;
    end
    if (rd_valid && rd_ready) begin
      f_next.rp = f_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end
endmodule

// ---- ifm_slave.sv ----
// Purpose: Two-wire serial slave in front of a 32K by 8 nonvolatile array.
// Assumes: Bus clock and data are sampled by clk; the bench resolves the wire.
// Notes:   Written bytes pass through a buffer before reaching the array.
`timescale 1ns/1ns
// Behaviour
// (RL1) First byte after START is slave address.
// (RL2) Upper four address bits must equal 1010.
// (RL3) Bits three to one match select pins.
// (RL4) Bit zero one reads, zero writes.
// (RL5) Master writes send address before data.
// (RL6) Store each written byte and acknowledge it.
// (RL7) Write address increments, wraps top to zero.
// (RL8) Latch points past last accessed byte.
// (RL9) Read header starts data on next clock.
// (RL10) Address increments after each read byte.
// (RL11) Received address bytes load the address latch.
// (RL12) Repeated START abandons write, then reads.
// (RL13) Array holds 32768 bytes, fifteen address bits.
// (RL14) Bus clock up to one megahertz.
// (RL15) Undriven select pin reads as zero.
// (RL16) Address high byte first, top bit ignored.
// (RL17) Mismatched address gets no acknowledge, ignored.
module ifm_slave import ifm_pkg::*; (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             scl,
  input  wire logic             sda,
  output logic                  sda_drv,
  output logic                  sda_oe,
  input  wire logic [SEL_W-1:0] device_select_pins
);
  typedef struct packed {
    logic              scl_s1;
    logic              scl_s2;
    logic              scl_s3;
    logic              sda_s1;
    logic              sda_s2;
    logic              sda_s3;
    logic [SEL_W-1:0]  sel_s1;
    logic [SEL_W-1:0]  sel_s2;
    ifm_state_t        st;
    ifm_phase_t        ph;
    logic [3:0]        cnt;
    logic [7:0]        shreg;
    logic              rw;
    logic              ack_ok;
    logic [6:0]        addr_hi;
    logic [ADDR_W-1:0] addr;
    logic              sda_oe;
    logic              sda_out;
  } ifm_state_st_t;

  ifm_state_st_t s_reg;
  ifm_state_st_t s_next;

  logic [DATA_W-1:0]  mem [0:MEM_DEPTH-1];
  logic [DATA_W-1:0]  rd_data_reg;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_cond;
  logic               stop_cond;
  logic               byte_end;
  logic               wr_push;
  logic               addr_load;
  logic               rd_load;
  logic               f_wr_ready;
  logic               f_rd_valid;
  logic               f_rd_ready;
  logic [ENTRY_W-1:0] f_rd_data;

  // Edges are found from the second and third stages only, never the first.
  assign scl_rise   = s_reg.scl_s2 && !s_reg.scl_s3;
  assign scl_fall   = !s_reg.scl_s2 && s_reg.scl_s3;
  assign start_cond = s_reg.scl_s2 && s_reg.scl_s3 && s_reg.sda_s3 && !s_reg.sda_s2;
  assign stop_cond  = s_reg.scl_s2 && s_reg.scl_s3 && !s_reg.sda_s3 && s_reg.sda_s2;
  assign byte_end   = (s_reg.st == ST_RECV) && (s_reg.cnt == BYTE_BITS) && scl_fall
                      && !start_cond && !stop_cond;
  assign wr_push    = byte_end && (s_reg.ph == PH_DATA) && f_wr_ready;
  assign addr_load  = byte_end && (s_reg.ph == PH_ALO);
  assign rd_load    = scl_fall && !start_cond && !stop_cond
                      && (((s_reg.st == ST_ACK) && (s_reg.ph == PH_DEV) && s_reg.rw)
                      || ((s_reg.st == ST_RACK) && s_reg.ack_ok));
  // Draining stalls while read data is on the wire; no byte is pushed in that state.
  assign f_rd_ready = (s_reg.st != ST_SEND);

  assign sda_oe  = s_reg.sda_oe;
  assign sda_drv = s_reg.sda_out;

  always_comb begin
    s_next = s_reg;
    // Bus lines and strap pins are foreign to clk and pass two stages first.
    s_next.scl_s1  = scl; // RL14
    s_next.scl_s2  = s_reg.scl_s1;
    s_next.scl_s3  = s_reg.scl_s2;
    s_next.sda_s1  = sda;
    s_next.sda_s2  = s_reg.sda_s1;
    s_next.sda_s3  = s_reg.sda_s2;
    // An open strap is pulled low outside, so it arrives here as zero.
    s_next.sel_s1  = device_select_pins; // RL15
    s_next.sel_s2  = s_reg.sel_s1;
    s_next.sda_out = 1'b0;
    if (start_cond) begin
      s_next.st     = ST_RECV; // RL1 RL12
      s_next.ph     = PH_DEV;
      s_next.cnt    = 4'h0;
      s_next.sda_oe = 1'b0;
    end else if (stop_cond) begin
      s_next.st     = ST_IDLE;
      s_next.sda_oe = 1'b0;
    end else begin
      case (s_reg.st)
        ST_IDLE: begin
          s_next.sda_oe = 1'b0;
        end
        ST_RECV: begin
          if (scl_rise && (s_reg.cnt != BYTE_BITS)) begin
            s_next.shreg = {s_reg.shreg[6:0], s_reg.sda_s2};
            s_next.cnt   = s_reg.cnt + 4'h1;
          end else if (byte_end) begin
            s_next.st     = ST_ACK;
            s_next.sda_oe = 1'b1;
            case (s_reg.ph)
              PH_DEV: begin
                if ((s_reg.shreg[SA_TYPE_HI:SA_TYPE_LO] != DEV_TYPE) // RL2
                    || (s_reg.shreg[SA_SEL_HI:SA_SEL_LO] != s_reg.sel_s2)) begin // RL3
                  s_next.st     = ST_IDLE; // RL17
                  s_next.sda_oe = 1'b0;
                end
                s_next.rw = s_reg.shreg[SA_RW]; // RL4
              end
              PH_AHI: begin
                // The top bit of the high address byte has no meaning.
                s_next.addr_hi = s_reg.shreg[6:0]; // RL16
              end
              PH_ALO: begin
                s_next.addr = {s_reg.addr_hi, s_reg.shreg}; // RL11 RL16
              end
              PH_DATA: begin
                // A full buffer refuses the byte rather than lose it silently.
                if (f_wr_ready) begin
                  s_next.addr = s_reg.addr + ADDR_ONE; // RL6 RL7 RL8
                end else begin
                  s_next.st     = ST_IDLE;
                  s_next.sda_oe = 1'b0;
                end
              end
              default: begin
                s_next.st = ST_IDLE;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (rd_load) begin
            s_next.st     = ST_SEND; // RL9
            s_next.sda_oe = !rd_data_reg[7];
            s_next.shreg  = {rd_data_reg[6:0], 1'b0};
            s_next.cnt    = 4'h1;
            s_next.addr   = s_reg.addr + ADDR_ONE; // RL10 RL8
          end else if (scl_fall) begin
            // Address bytes always precede data bytes of a write.
            s_next.st     = ST_RECV; // RL5
            s_next.sda_oe = 1'b0;
            s_next.cnt    = 4'h0;
            case (s_reg.ph)
              PH_DEV:  s_next.ph = PH_AHI;
              PH_AHI:  s_next.ph = PH_ALO;
              default: s_next.ph = PH_DATA;
            endcase
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (s_reg.cnt == BYTE_BITS) begin
              s_next.st     = ST_RACK;
              s_next.sda_oe = 1'b0;
            end else begin
              s_next.sda_oe = !s_reg.shreg[7];
              s_next.shreg  = {s_reg.shreg[6:0], 1'b0};
              s_next.cnt    = s_reg.cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            s_next.ack_ok = !s_reg.sda_s2;
          end else if (rd_load) begin
            s_next.st     = ST_SEND;
            s_next.sda_oe = !rd_data_reg[7];
            s_next.shreg  = {rd_data_reg[6:0], 1'b0};
            s_next.cnt    = 4'h1;
            s_next.addr   = s_reg.addr + ADDR_ONE; // RL10
          end else if (scl_fall) begin
            s_next.st = ST_IDLE;
          end
        end
        default: begin
          s_next.st     = ST_IDLE;
          s_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  ifm_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_valid (wr_push),
    .wr_ready (f_wr_ready),
    .wr_data  ({s_reg.addr, s_reg.shreg}),
    .rd_valid (f_rd_valid),
    .rd_ready (f_rd_ready),
    .rd_data  (f_rd_data)
  );

  // The array read is registered; a byte is fetched long before it is sent.
  always_ff @(posedge clk) begin
    if (f_rd_valid && f_rd_ready) begin
      mem[f_rd_data[ENTRY_W-1:DATA_W]] <= f_rd_data[DATA_W-1:0]; // RL6 RL13
    end
    rd_data_reg <= mem[s_reg.addr]; // RL13
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_START_DEV: assert property ( // RL1 RL12
    start_cond |=> (s_reg.st == ST_RECV) && (s_reg.ph == PH_DEV) && (s_reg.cnt == 4'h0)
  ) else $error("start did not open an address byte");

  AST_TYPE_NACK: assert property ( // RL2 RL17
    byte_end && (s_reg.ph == PH_DEV) && (s_reg.shreg[SA_TYPE_HI:SA_TYPE_LO] != DEV_TYPE)
    |=> (s_reg.st == ST_IDLE) && !sda_oe [*2]
  ) else $error("wrong device type was acknowledged");

  AST_SEL_NACK: assert property ( // RL3 RL17
    byte_end && (s_reg.ph == PH_DEV) && (s_reg.shreg[SA_SEL_HI:SA_SEL_LO] != s_reg.sel_s2)
    |=> !sda_oe && (s_reg.st == ST_IDLE)
  ) else $error("wrong select bits were acknowledged");

  AST_MATCH_ACK: assert property ( // RL2 RL3
    byte_end && (s_reg.ph == PH_DEV) && (s_reg.shreg[SA_TYPE_HI:SA_TYPE_LO] == DEV_TYPE)
    && (s_reg.shreg[SA_SEL_HI:SA_SEL_LO] == s_reg.sel_s2)
    |=> sda_oe && (s_reg.st == ST_ACK) && (s_reg.rw == $past(s_reg.shreg[SA_RW]))
  ) else $error("matching address was not acknowledged");

  AST_READ_START: assert property ( // RL4 RL9
    scl_fall && (s_reg.st == ST_ACK) && (s_reg.ph == PH_DEV) && s_reg.rw
    && !start_cond && !stop_cond
    |=> (s_reg.st == ST_SEND) && (sda_oe == !$past(rd_data_reg[7]))
  ) else $error("read data did not start after the header");

  AST_WRITE_ACK: assert property ( // RL6
    wr_push |=> sda_oe && (s_reg.st == ST_ACK)
  ) else $error("written byte was not acknowledged");

  AST_WRAP: assert property ( // RL7
    wr_push && (s_reg.addr == ADDR_TOP) |=> (s_reg.addr == ADDR_ZERO)
  ) else $error("write address did not wrap to zero");

  AST_ADDR_LOAD: assert property ( // RL11 RL16
    addr_load |=> (s_reg.addr == {$past(s_reg.addr_hi), $past(s_reg.shreg)})
  ) else $error("address latch not loaded from the header");

  AST_READ_INC: assert property ( // RL10 RL8
    rd_load |=> (s_reg.addr == $past(s_reg.addr) + ADDR_ONE)
  ) else $error("read address did not advance");

  AST_OPEN_DRAIN: assert property ( // RL14
    sda_oe |-> (sda_drv == 1'b0)
  ) else $error("data line driven high");

  AST_LOW_PHASE: assert property ( // RL9
    $changed(sda_oe) |-> !s_reg.scl_s2
  ) else $error("data line moved while the bus clock was high");

  AST_STOP_IDLE: assert property ( // RL1
    stop_cond |=> (s_reg.st == ST_IDLE) && !sda_oe
  ) else $error("stop did not return to idle");

  AST_START_QUIET: assert property ( // RL12
    start_cond |=> !sda_oe
  ) else $error("start left the data line driven");

  AST_AHI_LOAD: assert property ( // RL16
    byte_end && (s_reg.ph == PH_AHI) |=> (s_reg.addr_hi == $past(s_reg.shreg[6:0]))
  ) else $error("high address byte not kept");

  AST_ALO_ACK: assert property ( // RL11
    addr_load |=> sda_oe && (s_reg.st == ST_ACK)
  ) else $error("low address byte was not acknowledged");

  AST_ACK_RELEASE: assert property ( // RL6
    (s_reg.st == ST_ACK) && scl_fall && !rd_load && !start_cond && !stop_cond
    |=> !sda_oe && (s_reg.st == ST_RECV)
  ) else $error("acknowledge held past its clock");

  AST_SEND_BIT: assert property ( // RL9
    (s_reg.st == ST_SEND) && scl_fall && (s_reg.cnt != BYTE_BITS) && !start_cond && !stop_cond
    |=> (sda_oe == !$past(s_reg.shreg[7]))
  ) else $error("read bit not put on the line");

  AST_SEND_END: assert property ( // RL10
    (s_reg.st == ST_SEND) && scl_fall && (s_reg.cnt == BYTE_BITS) && !start_cond && !stop_cond
    |=> !sda_oe && (s_reg.st == ST_RACK)
  ) else $error("line not released after eight read bits");

  AST_NACK_IDLE: assert property ( // RL10
    (s_reg.st == ST_RACK) && scl_fall && !s_reg.ack_ok && !start_cond && !stop_cond
    |=> (s_reg.st == ST_IDLE)
  ) else $error("read went on after the master refused");

  AST_WRITE_INC: assert property ( // RL7 RL8
    wr_push |=> (s_reg.addr == $past(s_reg.addr) + ADDR_ONE)
  ) else $error("write address did not advance");

  AST_IDLE_QUIET: assert property ( // RL17
    (s_reg.st == ST_IDLE) |-> !sda_oe
  ) else $error("data line driven while ignoring the bus");

  AST_RECV_QUIET: assert property ( // RL5
    (s_reg.st == ST_RECV) |-> !sda_oe
  ) else $error("data line driven while receiving");

  AST_SEND_READS: assert property ( // RL4
    (s_reg.st == ST_SEND) |-> s_reg.rw
  ) else $error("data sent under a write header");

  COV_WRITE:  cover property (wr_push ##[1:300] wr_push);
  COV_READ:   cover property (rd_load ##[1:300] rd_load);
  COV_NACK:   cover property (byte_end && (s_reg.ph == PH_DEV) ##1 (s_reg.st == ST_IDLE));
  COV_RANDOM: cover property (addr_load ##[1:300] start_cond ##[1:300] rd_load);
  COV_SEL_ZERO: cover property (byte_end && (s_reg.ph == PH_DEV) && (s_reg.sel_s2 == '0) ##1 sda_oe);
endmodule

// ---- ifm_master.sv ----
// Purpose: Bus master model that clocks bytes into and out of the slave.
// Assumes: The wire level is resolved outside from both open-drain enables.
// Notes:   Each bus clock phase of a data bit is four system cycles, a period of 800 ns.
`timescale 1ns/1ns
module ifm_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe  = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves only in the low phase, so a bit can never pass for START or STOP.
  task automatic bit_io(input logic v, output logic s);
    wt(3);
    sda_oe = ~v;
    wt(1);
    scl = 1'b1;
    wt(2);
    s = sda;
    wt(2);
    scl = 1'b0;
  endtask
  // The same sequence serves as a repeated START after any byte except an acknowledged read header or a read byte that the master acknowledges.
  task automatic start();
    wt(3);
    sda_oe = 1'b0;
    wt(1);
    scl = 1'b1;
    wt(4);
    sda_oe = 1'b1;
    wt(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(3);
    sda_oe = 1'b1;
    wt(1);
    scl = 1'b1;
    wt(4);
    sda_oe = 1'b0;
    wt(4);
  endtask
  // Headers carry type, select and direction; addresses go high byte first.
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for the two-wire memory slave.
// Assumes: Open-drain wire with a pull-up; select straps with weak pull-downs.
// Notes:   The write buffer drains too fast to fill through the pins alone.
`timescale 1ns/1ns
module testbench;
  import ifm_pkg::*;
  logic             clk;
  logic             rst_b;
  logic             scl;
  logic             m_oe;
  logic             sda_drv;
  logic             sda_oe;
  logic             sda;
  logic [SEL_W-1:0] sel_drv;
  tri0  [SEL_W-1:0] sel_pins;
  int               n_fail;
  int               n_compared;
  logic             ack;
  logic [7:0]       rd;
  assign sel_pins = sel_drv;
  assign sda      = ~(m_oe | (sda_oe & ~sda_drv));
  initial clk = 1'b0;
  always #50 clk = ~clk;
  ifm_slave u_dut (
    .clk                (clk),
    .rst_b              (rst_b),
    .scl                (scl),
    .sda                (sda),
    .sda_drv            (sda_drv),
    .sda_oe             (sda_oe),
    .device_select_pins (sel_pins)
  );
  ifm_master u_master (
    .clk     (clk),
    .sda     (sda),
    .scl     (scl),
    .sda_oe  (m_oe)
  );
  task automatic chk_ack(string name, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk_byte(string name, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [7:0] hdr(logic [3:0] t, logic [2:0] s, logic rw);
    return {t, s, rw};
  endfunction
  task automatic send(logic [7:0] b, logic exp);
    u_master.wr_byte(b, ack);
    chk_ack("ack", exp, ack);
  endtask
  task automatic set_addr(logic [2:0] s, logic [15:0] a);
    u_master.start();
    send(hdr(DEV_TYPE, s, 1'b0), 1'b1);
    send(a[15:8], 1'b1);
    send(a[7:0], 1'b1);
  endtask
  task automatic t_write();
    sel_drv = 3'b101;
    set_addr(3'b101, 16'h9234);
    for (int i = 0; i < 4; i++) begin
      send(8'h5a + 8'(i), 1'b1);
    end
    u_master.stop();
    $display("test write done");
  endtask
  // Top address bit differs from the write: it must be ignored.
  task automatic t_sel_read();
    set_addr(3'b101, 16'h1234);
    u_master.start();
    send(hdr(DEV_TYPE, 3'b101, 1'b1), 1'b1);
    for (int i = 0; i < 3; i++) begin
      u_master.rd_byte(i < 2, rd);
      chk_byte("read", 8'h5a + 8'(i), rd);
    end
    u_master.stop();
    u_master.start();
    send(hdr(DEV_TYPE, 3'b101, 1'b1), 1'b1);
    u_master.rd_byte(1'b0, rd);
    chk_byte("current", 8'h5d, rd);
    u_master.stop();
    set_addr(3'b101, 16'h1233);
    send(8'h77, 1'b1);
    u_master.stop();
    u_master.start();
    send(hdr(DEV_TYPE, 3'b101, 1'b1), 1'b1);
    u_master.rd_byte(1'b0, rd);
    chk_byte("after write", 8'h5a, rd);
    u_master.stop();
    $display("test selective read done");
  endtask
  task automatic t_wrap();
    set_addr(3'b101, 16'h7fff);
    send(8'hc3, 1'b1);
    send(8'h3c, 1'b1);
    u_master.stop();
    set_addr(3'b101, 16'hffff);
    u_master.start();
    send(hdr(DEV_TYPE, 3'b101, 1'b1), 1'b1);
    u_master.rd_byte(1'b1, rd);
    chk_byte("top", 8'hc3, rd);
    u_master.rd_byte(1'b0, rd);
    chk_byte("wrapped", 8'h3c, rd);
    u_master.stop();
    $display("test wrap done");
  endtask
  // After a refused header even a good-looking byte must stay unanswered.
  task automatic t_refuse();
    u_master.start();
    send(hdr(4'hb, 3'b101, 1'b0), 1'b0);
    send(hdr(DEV_TYPE, 3'b101, 1'b0), 1'b0);
    u_master.stop();
    u_master.start();
    send(hdr(DEV_TYPE, 3'b100, 1'b0), 1'b0);
    u_master.stop();
    $display("test refuse done");
  endtask
  task automatic t_pulldown();
    sel_drv = 3'bzzz;
    u_master.start();
    send(hdr(DEV_TYPE, 3'b000, 1'b0), 1'b1);
    u_master.stop();
    u_master.start();
    send(hdr(DEV_TYPE, 3'b001, 1'b0), 1'b0);
    u_master.stop();
    $display("test pulldown done");
  endtask
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // A full run takes well under half a millisecond of bus traffic.
  initial begin
    #2_000_000;
    n_fail++;
    end_of_test();
  end
  initial begin
    n_fail     = 0;
    n_compared = 0;
    rst_b      = 1'b0;
    sel_drv    = 3'b101;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (8) @(negedge clk);
    t_write();
    t_sel_read();
    t_wrap();
    t_refuse();
    t_pulldown();
    end_of_test();
  end
endmodule
